// [srh_host.sv]
// Host controller that drives a 64K x 4 asynchronous static RAM
`timescale 1ns/1ps
`default_nettype none
`include "srh_defines.svh"
module srh_host (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqStream,
    input wire logic [`SRH_ROW_W-1:0] reqRow,
    input wire logic [`SRH_ROW_W-1:0] reqCol,
    input wire logic [`SRH_DATA_W-1:0] reqData,
    output logic reqReady,
    output logic rspValid,
    output logic [`SRH_DATA_W-1:0] rspData,
    output logic [`SRH_ADDR_W-1:0] wordAddress,
    output logic chipSel_n,
    output logic writeStb_n,
    output logic outEn_n,
    input wire logic [`SRH_DATA_W-1:0] dataIoIn,
    output logic [`SRH_DATA_W-1:0] dataIoOut,
    output logic dataIoOe
);
    srh_pkg::srh_state_e state_ff;
    logic isWrite_ff;
    logic [1:0] cnt_ff;
    logic [`SRH_DATA_W-1:0] syncData;
    logic syncStable;
    logic cntDone;

    srh_in_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(dataIoIn),
        .syncOut(syncData),
        .stable(syncStable)
    );

    assign cntDone = (cnt_ff == `SRH_CNT_ZERO);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff <= srh_pkg::ST_IDLE;
            cnt_ff <= `SRH_CNT_ZERO;
            isWrite_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                srh_pkg::ST_IDLE:
                begin
                    // Start only on a handshake, the edge on which the pins latch too
                    if (reqValid && reqReady)
                    begin
                        isWrite_ff <= reqWrite;
                        cnt_ff <= `SRH_SETUP_CYC;
                        if (!reqWrite && reqStream)
                            state_ff <= srh_pkg::ST_STREAM;
                        else
                            state_ff <= srh_pkg::ST_SETUP;
                    end
                end
                // Address is already stable before chip select drops
                srh_pkg::ST_SETUP:
                begin
                    if (cntDone)
                    begin
                        cnt_ff <= `SRH_STROBE_CYC;
                        state_ff <= srh_pkg::ST_STROBE;
                    end
                    else
                        cnt_ff <= cnt_ff - `SRH_CNT_ONE;
                end
                srh_pkg::ST_STROBE:
                begin
                    if (cntDone)
                    begin
                        cnt_ff <= `SRH_HOLD_CYC;
                        state_ff <= srh_pkg::ST_HOLD;
                    end
                    else
                        cnt_ff <= cnt_ff - `SRH_CNT_ONE;
                end
                // Write data and address outlast the strobe by this hold
                srh_pkg::ST_HOLD:
                begin
                    if (cntDone)
                        state_ff <= isWrite_ff ? srh_pkg::ST_IDLE : srh_pkg::ST_SAMPLE;
                    else
                        cnt_ff <= cnt_ff - `SRH_CNT_ONE;
                end
                // Wait until the synchroniser has settled on the read word
                srh_pkg::ST_SAMPLE:
                begin
                    if (syncStable)
                        state_ff <= srh_pkg::ST_IDLE;
                end
                srh_pkg::ST_STREAM:
                begin
                    if (!reqValid || reqWrite || !reqStream)
                        state_ff <= srh_pkg::ST_IDLE;
                end
                default:
                    state_ff <= srh_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins toward the RAM
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wordAddress <= `SRH_ADDR_RST;
            chipSel_n <= 1'b1;
            writeStb_n <= 1'b1;
            outEn_n <= 1'b1;
            dataIoOut <= `SRH_DATA_RST;
            dataIoOe <= 1'b0;
        end
        else
        begin
            // Row on the upper address bits, column on the lower
            if (reqValid && reqReady)
            begin
                wordAddress[`SRH_ROW_HI:`SRH_ROW_LO] <= reqRow;
                wordAddress[`SRH_COL_HI:`SRH_COL_LO] <= reqCol;
                dataIoOut <= reqData;
            end
            case (state_ff)
                srh_pkg::ST_SETUP:
                begin
                    // Select first, strobe two cycles later, so the write never
                    // lets the RAM drive mid-cycle
                    chipSel_n <= !cntDone;
                    dataIoOe <= isWrite_ff;
                    outEn_n <= !(cntDone && !isWrite_ff);
                end
                srh_pkg::ST_STROBE:
                begin
                    writeStb_n <= !isWrite_ff || !cntDone;
                end
                srh_pkg::ST_HOLD:
                begin
                    // Strobe rises first; select drops one cycle after
                    writeStb_n <= 1'b1;
                    if (cntDone)
                    begin
                        chipSel_n <= 1'b1;
                        outEn_n <= 1'b1;
                        dataIoOe <= 1'b0;
                    end
                end
                srh_pkg::ST_STREAM:
                begin
                    chipSel_n <= 1'b0;
                    outEn_n <= 1'b0;
                    writeStb_n <= 1'b1;
                    dataIoOe <= 1'b0;
                end
                default:
                begin
                    chipSel_n <= 1'b1;
                    writeStb_n <= 1'b1;
                    outEn_n <= 1'b1;
                    dataIoOe <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // User side
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspData <= `SRH_DATA_RST;
        end
        else
        begin
            reqReady <= (state_ff == srh_pkg::ST_IDLE && !(reqValid && reqReady))
                || (state_ff == srh_pkg::ST_STREAM && reqValid && reqStream && !reqWrite);
            rspValid <= 1'b0;
            if (state_ff == srh_pkg::ST_SAMPLE && syncStable)
            begin
                rspValid <= 1'b1;
                rspData <= syncData;
            end
            else if (state_ff == srh_pkg::ST_STREAM && syncStable)
            begin
                rspValid <= 1'b1;
                rspData <= syncData;
            end
        end
    end
endmodule : srh_host
`default_nettype wire

// [srh_defines.svh]
// Constants for the static RAM host controller
`ifndef SRH_DEFINES_SVH
`define SRH_DEFINES_SVH
`define SRH_ADDR_W 16
`define SRH_DATA_W 4
`define SRH_ROW_W 8
`define SRH_ROW_HI 15
`define SRH_ROW_LO 8
`define SRH_COL_HI 7
`define SRH_COL_LO 0
`define SRH_ADDR_RST 16'h0000
`define SRH_DATA_RST 4'h0
`define SRH_SYNC_RST 3'h0
`define SRH_SETUP_CYC 2'h1
`define SRH_STROBE_CYC 2'h1
`define SRH_HOLD_CYC 2'h1
`define SRH_CNT_ZERO 2'h0
`define SRH_CNT_ONE 2'h1
`endif

// [srh_pkg.sv]
// Types of the static RAM host controller
`default_nettype none
package srh_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_SAMPLE,
        ST_STREAM
    } srh_state_e;
endpackage : srh_pkg
`default_nettype wire

// [srh_in_sync.sv]
// Three-stage synchroniser for the data pins read back from the RAM
`timescale 1ns/1ps
`default_nettype none
`include "srh_defines.svh"
module srh_in_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`SRH_DATA_W-1:0] pinIn,
    output logic [`SRH_DATA_W-1:0] syncOut,
    output logic stable
);
    logic [`SRH_DATA_W-1:0] stage1_ff;
    logic [`SRH_DATA_W-1:0] stage2_ff;
    logic [`SRH_DATA_W-1:0] stage3_ff;

    genvar i;
    generate
        for (i = 0; i < `SRH_DATA_W; i = i + 1)
        begin : g_bit
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    stage1_ff[i] <= 1'b0;
                    stage2_ff[i] <= 1'b0;
                    stage3_ff[i] <= 1'b0;
                end
                else
                begin
                    stage1_ff[i] <= pinIn[i];
                    stage2_ff[i] <= stage1_ff[i];
                    stage3_ff[i] <= stage2_ff[i];
                end
            end
        end
    endgenerate

    // A value counts once the second and third stages agree
    assign syncOut = stage3_ff;
    assign stable = (stage2_ff == stage3_ff);
endmodule : srh_in_sync
`default_nettype wire

// [srh_ram_model.sv]
// Behavioural 64K x 4 static RAM seen from the host controller
`timescale 1ns/1ps
`default_nettype none
`include "srh_defines.svh"
module srh_ram_model (
    input wire logic [`SRH_ADDR_W-1:0] wordAddress,
    input wire logic chipSel_n,
    input wire logic writeStb_n,
    input wire logic outEn_n,
    input wire logic [`SRH_DATA_W-1:0] dataIoOut,
    input wire logic dataIoOe,
    output logic [`SRH_DATA_W-1:0] dataIoIn
);
    logic [`SRH_DATA_W-1:0] cells [0:255][0:255];
    logic [`SRH_DATA_W-1:0] lastBus = 4'h0;
    logic ramDrive;
    // Drives only in a true read; a write floats the pins whatever outEn_n is
    assign ramDrive = !chipSel_n && writeStb_n && !outEn_n;
    // No clock: the array follows the control levels
    always @(wordAddress or chipSel_n or writeStb_n or dataIoOut or ramDrive)
    begin
        if (!chipSel_n && !writeStb_n)
            cells[wordAddress[15:8]][wordAddress[7:0]] = dataIoOut;
        if (ramDrive)
            lastBus = cells[wordAddress[15:8]][wordAddress[7:0]];
    end
    // A floating bus shows the inverse of the last word the RAM drove so stale data cannot pass
    assign dataIoIn = dataIoOe ? dataIoOut :
        ramDrive ? cells[wordAddress[15:8]][wordAddress[7:0]] : ~lastBus;
endmodule : srh_ram_model
`default_nettype wire

// [srh_host_props.sv]
// Port checker for the static RAM host controller
`timescale 1ns/1ps
`default_nettype none
`include "srh_defines.svh"
module srh_host_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqStream,
    input wire logic [`SRH_ROW_W-1:0] reqRow,
    input wire logic [`SRH_ROW_W-1:0] reqCol,
    input wire logic [`SRH_DATA_W-1:0] reqData,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic [`SRH_DATA_W-1:0] rspData,
    input wire logic [`SRH_ADDR_W-1:0] wordAddress,
    input wire logic chipSel_n,
    input wire logic writeStb_n,
    input wire logic outEn_n,
    input wire logic [`SRH_DATA_W-1:0] dataIoIn,
    input wire logic [`SRH_DATA_W-1:0] dataIoOut,
    input wire logic dataIoOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence take_s;
        reqValid && reqReady;
    endsequence
    sequence write_take_s;
        take_s ##0 reqWrite;
    endsequence
    read_strobe_a: assert property (!chipSel_n && !outEn_n |-> writeStb_n)
        else $error("write strobe low in a read");
    write_drive_a: assert property (!writeStb_n |-> !chipSel_n && dataIoOe)
        else $error("write strobe outside select or undriven data");
    strobe_inside_a: assert property ($fell(writeStb_n) |-> $past(chipSel_n) == 1'b0)
        else $error("write strobe fell before chip select");
    strobe_release_a: assert property ($rose(chipSel_n) |-> $past(writeStb_n))
        else $error("chip select rose before write strobe");
    addr_settled_a: assert property ($fell(chipSel_n) |-> $stable(wordAddress))
        else $error("address moved as chip select fell");
    write_hold_a: assert property (!writeStb_n |-> $stable(wordAddress) && $stable(dataIoOut))
        else $error("address or data moved during write");
    addr_map_a: assert property (take_s |=> wordAddress == {$past(reqRow), $past(reqCol)})
        else $error("address not row then column");
    data_map_a: assert property (write_take_s |=> dataIoOut == $past(reqData))
        else $error("write data not taken");
    no_fight_a: assert property (!outEn_n |-> !dataIoOe)
        else $error("host drives pins while output enabled");
endmodule : srh_host_props
bind srh_host srh_host_props i_srh_host_props (.clk, .rst_n, .reqValid, .reqWrite, .reqStream,
    .reqRow, .reqCol, .reqData, .reqReady, .rspValid, .rspData, .wordAddress, .chipSel_n,
    .writeStb_n, .outEn_n, .dataIoIn, .dataIoOut, .dataIoOe);
`default_nettype wire

// [srh_host_tb_top.sv]
// Self-checking bench for the static RAM host controller
`timescale 1ns/1ps
`default_nettype none
`include "srh_defines.svh"
module srh_host_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqStream = 1'b0;
    logic [7:0] reqRow = 8'h00, reqCol = 8'h00;
    logic [3:0] reqData = 4'h0, rspData, dataIoIn, dataIoOut;
    logic [15:0] wordAddress;
    logic reqReady, rspValid, chipSel_n, writeStb_n, outEn_n, dataIoOe;
    int errors = 0, tests_run = 0;
    logic [15:0] testAddr [4] = '{16'h0000, 16'hffff, 16'h12ab, 16'hab12};
    logic [3:0] testData [4] = '{4'h5, 4'ha, 4'h3, 4'hc};
    srh_host i_srh_host (.clk, .rst_n, .reqValid, .reqWrite, .reqStream, .reqRow, .reqCol,
        .reqData, .reqReady, .rspValid, .rspData, .wordAddress, .chipSel_n, .writeStb_n,
        .outEn_n, .dataIoIn, .dataIoOut, .dataIoOe);
    srh_ram_model i_srh_ram_model (.wordAddress, .chipSel_n, .writeStb_n, .outEn_n,
        .dataIoOut, .dataIoOe, .dataIoIn);
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [3:0] g, input logic [3:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
            errors++;
        end
    endtask : chk
    // Stream requests keep reqValid up so the controller stays selected
    task automatic go(input logic w, input logic s, input logic [15:0] a, input logic [3:0] d);
        int n = 0;
        @(posedge clk);
        reqValid <= 1'b1;
        {reqWrite, reqStream, reqRow, reqCol, reqData} <= {w, s, a, d};
        do
        begin
            @(negedge clk);
            n++;
        end
        while (reqReady !== 1'b1 && n < 40);
        // A request never accepted counts as a mismatch, not a silent pass
        chk({3'h0, reqReady}, 4'h1);
        @(posedge clk);
        reqValid <= s;
    endtask : go
    task automatic rsp(input logic [3:0] e);
        int n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (!(rspValid === 1'b1 && (!reqStream || rspData === e)) && n < 60);
        // A missing answer must fail even if stale read data happens to match
        chk({3'h0, rspValid}, 4'h1);
        chk(rspData, e);
    endtask : rsp
    task automatic rd(input logic [15:0] a, input logic [3:0] e);
        go(1'b0, 1'b0, a, 4'h0);
        rsp(e);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_rw;
        for (int i = 0; i < 4; i++) go(1'b1, 1'b0, testAddr[i], testData[i]);
        for (int i = 0; i < 4; i++) rd(testAddr[i], testData[i]);
        $display("t_rw done");
    endtask : t_rw
    task automatic t_over;
        go(1'b1, 1'b0, 16'h0f0f, 4'h9);
        go(1'b1, 1'b0, 16'h0f0f, 4'h6);
        rd(16'h0f0f, 4'h6);
        $display("t_over done");
    endtask : t_over
    task automatic t_stream;
        for (int i = 1; i < 4; i++)
        begin
            go(1'b0, 1'b1, testAddr[i], 4'h0);
            rsp(testData[i]);
        end
        @(posedge clk);
        {reqValid, reqStream} <= 2'b00;
        $display("t_stream done");
    endtask : t_stream
    task automatic t_reset;
        go(1'b1, 1'b0, 16'h5555, 4'h1);
        repeat (3) @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk({chipSel_n, writeStb_n, outEn_n, dataIoOe}, 4'he);
        @(posedge clk);
        rst_n <= 1'b1;
        rd(16'hab12, 4'hc);
        $display("t_reset done");
    endtask : t_reset
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_rw();
        t_over();
        t_stream();
        t_reset();
        conclude();
    end
    // Whole run needs about 133 cycles; this allows about thirty times that
    initial
    begin
        #200000;
        errors++;
        conclude();
    end
endmodule : srh_host_tb_top
`default_nettype wire
